// ==== rtl/tlp_irq_prio.sv ====
/*
  Two-level interrupt prioritizer with Wishbone register slave.
  Assumes the core pulses instr_done_i at each instruction end, with
  instr_is_return_from_isr_i marking a return, and jumps on take_vector_o.
*/
`timescale 1ns/1ps
`default_nettype none
module tlp_irq_prio
  import tlp_pkg::*;
#(
  parameter logic [7:0] PFAIL_VECTOR = 8'h33  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  timer_control_reg_i,
  input  wire logic [7:0]  serial0_control_reg_i,
  input  wire logic [7:0]  serial1_control_reg_i,
  input  wire logic [7:0]  timer2_control_reg_i,
  input  wire logic        adc_event_i,
  input  wire logic        ext0_request_n_i,
  input  wire logic        ext2_request_i,
  input  wire logic        power_fail_i,
  input  wire logic        spi_rx_overrun_i,
  input  wire logic        spi_tx_empty_i,
  input  wire logic        spi_rx_avail_i,
  input  wire logic        instr_done_i,
  input  wire logic        instr_is_return_from_isr_i,
  output logic             take_vector_o,
  output logic      [7:0]  vector_o,
  output logic      [1:0]  active_level_o,
  output logic             serial1_baud_double_o
);

  logic [7:0] irq_enable_mask_ff;
  logic [7:0] irq_level_select_ff;
  logic [7:0] extended_enable_mask_ff;
  logic [7:0] extended_level_select_ff;
  logic       adc_flag_ff;
  logic       ext0_flag_ff;
  logic       ext2_flag_ff;
  logic       baud_dbl_ff;
  logic [7:0] pending_cause_ff;
  logic       adc_prev_ff;
  logic       ext0_prev_ff;
  logic       ext2_prev_ff;
  logic       isr_low_ff;
  logic       isr_high_ff;
  logic       isr_pfail_ff;
  logic       mask_wr_seen_ff;
  tlp_level_t level_ff;
  logic       ack_ff;
  logic [31:0] rd_ff;
  logic       take_ff;
  logic [7:0] vector_ff;

  logic       bus_req;
  logic       wr_commit;
  logic [7:0] reg_idx;
  logic       wr_lane0;
  logic       mask_wr;
  logic [7:0] nxt_rd;
  logic [9:0] src_req;
  logic [9:0] src_en;
  logic [9:0] src_lvl;
  logic [9:0] gated;
  logic [3:0] win_idx;
  logic       win_valid;
  tlp_level_t win_lvl;
  tlp_level_t cur_lvl;
  logic [7:0] win_vec;
  logic       take_now;
  logic       hold_now;
  logic       nxt_isr_low;
  logic       nxt_isr_high;
  logic       nxt_isr_pfail;
  tlp_level_t nxt_level;

  // Lowest index set, 4'hF when none
  function automatic logic [3:0] first_set(input logic [9:0] v);
    logic [3:0] r;
    r = 4'hF;
    for (int i = TLP_N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Read one register byte with forced-one reserved bits
  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [7:0] en,
                                         input logic [7:0] lvl, input logic [7:0] een,
                                         input logic [7:0] elvl, input logic [7:0] flg,
                                         input logic [7:0] e2c, input logic [7:0] cause);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      TLP_IDX_EXT_FLAGS: r = flg | TLP_RO1_EXT_FLAGS;
      TLP_IDX_ENABLE:    r = en;
      TLP_IDX_LEVEL:     r = lvl | TLP_RO1_LEVEL;
      TLP_IDX_EXT2_CTL:  r = e2c | TLP_RO1_EXT2_CTL;
      TLP_IDX_CAUSE:     r = cause;
      TLP_IDX_EXT_EN:    r = een | TLP_RO1_EXT_EN;
      TLP_IDX_EXT_LVL:   r = elvl;
      default:           r = 8'h00;
    endcase
    return r;
  endfunction

  // Level encoded by a set of in-service markers
  function automatic tlp_level_t level_of(input logic pf, input logic hi, input logic lo);
    tlp_level_t r;
    if (pf) begin
      r = TLP_LVL_PFAIL;
    end else if (hi) begin
      r = TLP_LVL_HIGH;
    end else if (lo) begin
      r = TLP_LVL_LOW;
    end else begin
      r = TLP_LVL_NONE;
    end
    return r;
  endfunction

  // Bus decode; a write lands on the edge where the master sees ack
  always_comb begin
    bus_req   = wb_cyc_i & wb_stb_i;
    reg_idx   = wb_adr_i[9:2];
    wr_commit = bus_req & wb_we_i & ack_ff;
    wr_lane0  = wr_commit & wb_sel_i[0];
    mask_wr   = wr_lane0 & ((reg_idx == TLP_IDX_ENABLE) | (reg_idx == TLP_IDX_LEVEL) |
                            (reg_idx == TLP_IDX_EXT_EN) | (reg_idx == TLP_IDX_EXT_LVL));
    nxt_rd    = rd_byte(reg_idx, irq_enable_mask_ff, irq_level_select_ff,
                        extended_enable_mask_ff, extended_level_select_ff,
                        {2'b00, ext0_flag_ff, adc_flag_ff, 4'h0},
                        {baud_dbl_ff, 3'b000, ext2_flag_ff, 3'b000}, pending_cause_ff);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_ff  <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff) begin
        rd_ff <= {24'h00_0000, nxt_rd};
      end
    end
  end

  // Software-owned masks and levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_mask_ff       <= TLP_REG_RESET;
      irq_level_select_ff      <= TLP_REG_RESET;
      extended_enable_mask_ff  <= TLP_REG_RESET;
      extended_level_select_ff <= TLP_REG_RESET;
      baud_dbl_ff              <= 1'b0;
    end else if (wr_lane0) begin
      case (reg_idx)
        TLP_IDX_ENABLE:   irq_enable_mask_ff       <= wb_dat_i[7:0];
        TLP_IDX_LEVEL:    irq_level_select_ff      <= {1'b0, wb_dat_i[6:0]};
        TLP_IDX_EXT_EN:   extended_enable_mask_ff  <= {3'b000, wb_dat_i[4], 2'b00, wb_dat_i[1:0]};
        TLP_IDX_EXT_LVL:  extended_level_select_ff <= {3'b000, wb_dat_i[4], 2'b00, wb_dat_i[1:0]};
        TLP_IDX_EXT2_CTL: baud_dbl_ff              <= wb_dat_i[TLP_B_BAUD_DBL];
        default:          baud_dbl_ff              <= baud_dbl_ff;
      endcase
    end
  end

  // Edge history for extended sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_prev_ff  <= 1'b0;
      ext0_prev_ff <= 1'b1;
      ext2_prev_ff <= 1'b0;
    end else begin
      adc_prev_ff  <= adc_event_i;
      ext0_prev_ff <= ext0_request_n_i;
      ext2_prev_ff <= ext2_request_i;
    end
  end

  // Extended flags: hardware edge sets win over software clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_flag_ff  <= 1'b0;
      ext0_flag_ff <= 1'b0;
      ext2_flag_ff <= 1'b0;
    end else begin
      if (adc_event_i & ~adc_prev_ff) begin
        adc_flag_ff <= 1'b1;
      end else if (wr_lane0 && reg_idx == TLP_IDX_EXT_FLAGS) begin
        adc_flag_ff <= wb_dat_i[TLP_B_ADC_F];
      end
      if (~ext0_request_n_i & ext0_prev_ff) begin
        ext0_flag_ff <= 1'b1;
      end else if (wr_lane0 && reg_idx == TLP_IDX_EXT_FLAGS) begin
        ext0_flag_ff <= wb_dat_i[TLP_B_EXT0_F];
      end
      if (ext2_request_i & ~ext2_prev_ff) begin
        ext2_flag_ff <= 1'b1;
      end else if (wr_lane0 && reg_idx == TLP_IDX_EXT2_CTL) begin
        ext2_flag_ff <= wb_dat_i[TLP_B_EXT2_F];
      end
    end
  end

  // Highest pending peripheral cause
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_cause_ff <= TLP_CAUSE_NONE;
    end else if (spi_rx_overrun_i) begin
      pending_cause_ff <= TLP_CAUSE_OVERRUN;
    end else if (spi_tx_empty_i) begin
      pending_cause_ff <= TLP_CAUSE_TXEMPTY;
    end else if (spi_rx_avail_i) begin
      pending_cause_ff <= TLP_CAUSE_RXAVAIL;
    end else begin
      pending_cause_ff <= TLP_CAUSE_NONE;
    end
  end

  // Source table in natural order
  always_comb begin
    src_req = '0;
    src_req[TLP_S_PERIPH] = timer_control_reg_i[TLP_B_PERIPH_F];
    src_req[TLP_S_TMR0]   = timer_control_reg_i[TLP_B_TMR0_F];
    src_req[TLP_S_EXT1]   = timer_control_reg_i[TLP_B_EXT1_F];
    src_req[TLP_S_TMR1]   = timer_control_reg_i[TLP_B_TMR1_F];
    src_req[TLP_S_SER0]   = serial0_control_reg_i[TLP_B_SER_RX] | serial0_control_reg_i[TLP_B_SER_TX];
    src_req[TLP_S_TMR2]   = timer2_control_reg_i[TLP_B_TMR2_OVF] | timer2_control_reg_i[TLP_B_TMR2_EXT];
    src_req[TLP_S_SER1]   = serial1_control_reg_i[TLP_B_SER_RX] | serial1_control_reg_i[TLP_B_SER_TX];
    src_req[TLP_S_ADC]    = adc_flag_ff;
    src_req[TLP_S_EXT0]   = ext0_flag_ff;
    src_req[TLP_S_EXT2]   = ext2_flag_ff;
    src_en  = {extended_enable_mask_ff[TLP_B_EXT2_EN], extended_enable_mask_ff[TLP_B_EXT0_EN],
               extended_enable_mask_ff[TLP_B_ADC_EN], irq_enable_mask_ff[6:0]};
    src_lvl = {extended_level_select_ff[TLP_B_EXT2_EN], extended_level_select_ff[TLP_B_EXT0_EN],
               extended_level_select_ff[TLP_B_ADC_EN], irq_level_select_ff[6:0]};
    gated   = src_req & src_en & {TLP_N_SRC{irq_enable_mask_ff[TLP_B_GLOBAL]}};
  end

  // Winner: power-fail, then high level, then low; index breaks ties
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'hF;
    win_lvl   = TLP_LVL_NONE;
    win_vec   = 8'h00;
    if (power_fail_i) begin
      win_valid = 1'b1;
      win_lvl   = TLP_LVL_PFAIL;
      win_vec   = PFAIL_VECTOR;
    end else if (|(gated & src_lvl)) begin
      win_idx   = first_set(gated & src_lvl);
      win_valid = 1'b1;
      win_lvl   = TLP_LVL_HIGH;
    end else if (|gated) begin
      win_idx   = first_set(gated);
      win_valid = 1'b1;
      win_lvl   = TLP_LVL_LOW;
    end
    if (win_idx < 4'(TLP_N_SRC)) begin
      win_vec = TLP_VEC_TAB[win_idx];
    end
  end

  // Level of the routine in progress
  always_comb begin
    cur_lvl  = level_of(isr_pfail_ff, isr_high_ff, isr_low_ff);
    // A return or a mask/level write ends with no entry; the next boundary may enter
    hold_now = instr_is_return_from_isr_i | mask_wr_seen_ff | mask_wr;
    take_now = instr_done_i & ~hold_now & win_valid & (win_lvl > cur_lvl);
  end

  // Mask/level write committed during the instruction in progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_wr_seen_ff <= 1'b0;
    end else if (instr_done_i) begin
      mask_wr_seen_ff <= 1'b0;
    end else if (mask_wr) begin
      mask_wr_seen_ff <= 1'b1;
    end
  end

  // In-service markers: set on entry, highest cleared on return
  always_comb begin
    nxt_isr_low   = isr_low_ff;
    nxt_isr_high  = isr_high_ff;
    nxt_isr_pfail = isr_pfail_ff;
    if (take_now) begin
      case (win_lvl)
        TLP_LVL_LOW:   nxt_isr_low   = 1'b1;
        TLP_LVL_HIGH:  nxt_isr_high  = 1'b1;
        TLP_LVL_PFAIL: nxt_isr_pfail = 1'b1;
        default:       nxt_isr_low   = isr_low_ff;
      endcase
    end else if (instr_done_i & instr_is_return_from_isr_i) begin
      if (isr_pfail_ff) begin
        nxt_isr_pfail = 1'b0;
      end else if (isr_high_ff) begin
        nxt_isr_high = 1'b0;
      end else begin
        nxt_isr_low = 1'b0;
      end
    end
    nxt_level = level_of(nxt_isr_pfail, nxt_isr_high, nxt_isr_low);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_low_ff   <= 1'b0;
      isr_high_ff  <= 1'b0;
      isr_pfail_ff <= 1'b0;
    end else begin
      isr_low_ff   <= nxt_isr_low;
      isr_high_ff  <= nxt_isr_high;
      isr_pfail_ff <= nxt_isr_pfail;
    end
  end

  // Reported level in its own flop so the port is registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= TLP_LVL_NONE;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // Redirect pulse to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_ff   <= 1'b0;
      vector_ff <= 8'h00;
    end else begin
      take_ff <= take_now;
      if (take_now) begin
        vector_ff <= win_vec;
      end
    end
  end

  assign wb_ack_o              = ack_ff;
  assign wb_dat_o              = rd_ff;
  assign take_vector_o         = take_ff;
  assign vector_o              = vector_ff;
  assign active_level_o        = level_ff;
  assign serial1_baud_double_o = baud_dbl_ff;

endmodule
`default_nettype wire

// ==== rtl/tlp_pkg.sv ====
/*
  Constants for the two-level interrupt prioritizer: register indices,
  bit positions, vectors, cause codes and service levels.
  Assumes a 32-bit classic Wishbone slave; byte address = 4 * index.

*/
package tlp_pkg;
  // Register indices
  localparam logic [7:0] TLP_IDX_EXT_FLAGS = 8'h91;
  localparam logic [7:0] TLP_IDX_ENABLE    = 8'hA8;
  localparam logic [7:0] TLP_IDX_LEVEL     = 8'hB8;
  localparam logic [7:0] TLP_IDX_EXT2_CTL  = 8'hD8;
  localparam logic [7:0] TLP_IDX_CAUSE     = 8'hE4;
  localparam logic [7:0] TLP_IDX_EXT_EN    = 8'hE8;
  localparam logic [7:0] TLP_IDX_EXT_LVL   = 8'hF8;

  localparam logic [7:0] TLP_REG_RESET = 8'h00;

  // Bits read as one
  localparam logic [7:0] TLP_RO1_EXT_FLAGS = 8'h08;
  localparam logic [7:0] TLP_RO1_LEVEL     = 8'h80;
  localparam logic [7:0] TLP_RO1_EXT2_CTL  = 8'h40;
  localparam logic [7:0] TLP_RO1_EXT_EN    = 8'hE0;

  // Field positions
  localparam int TLP_B_GLOBAL    = 7;
  localparam int TLP_B_PERIPH_F  = 1;
  localparam int TLP_B_TMR0_F    = 5;
  localparam int TLP_B_EXT1_F    = 3;
  localparam int TLP_B_TMR1_F    = 7;
  localparam int TLP_B_SER_RX    = 0;
  localparam int TLP_B_SER_TX    = 1;
  localparam int TLP_B_TMR2_OVF  = 7;
  localparam int TLP_B_TMR2_EXT  = 6;
  localparam int TLP_B_ADC_F     = 4;
  localparam int TLP_B_EXT0_F    = 5;
  localparam int TLP_B_EXT2_F    = 3;
  localparam int TLP_B_BAUD_DBL  = 7;
  localparam int TLP_B_ADC_EN    = 0;
  localparam int TLP_B_EXT0_EN   = 1;
  localparam int TLP_B_EXT2_EN   = 4;

  // Natural order index of each source
  localparam int TLP_N_SRC = 10;
  localparam int TLP_S_PERIPH = 0;
  localparam int TLP_S_TMR0   = 1;
  localparam int TLP_S_EXT1   = 2;
  localparam int TLP_S_TMR1   = 3;
  localparam int TLP_S_SER0   = 4;
  localparam int TLP_S_TMR2   = 5;
  localparam int TLP_S_SER1   = 6;
  localparam int TLP_S_ADC    = 7;
  localparam int TLP_S_EXT0   = 8;
  localparam int TLP_S_EXT2   = 9;

  localparam logic [7:0] TLP_VEC_TAB [0:9] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
                                               8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h63};

  // Peripheral cause codes
  localparam logic [7:0] TLP_CAUSE_OVERRUN = 8'h01;
  localparam logic [7:0] TLP_CAUSE_TXEMPTY = 8'h03;
  localparam logic [7:0] TLP_CAUSE_RXAVAIL = 8'h05;
  localparam logic [7:0] TLP_CAUSE_NONE    = 8'h00;

  typedef enum logic [1:0] {
    TLP_LVL_NONE,
    TLP_LVL_LOW,
    TLP_LVL_HIGH,
    TLP_LVL_PFAIL
  } tlp_level_t;
endpackage

// ==== dv/tlp_irq_prio_properties.sv ====
/*
  Port checker for the prioritizer: bus answers and vector entry.
  Assumes it is bound onto tlp_irq_prio in a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tlp_irq_prio_props #(
  parameter logic [7:0] PFAIL_VECTOR = 8'h33
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        instr_done_i,
  input wire logic        instr_is_return_from_isr_i,
  input wire logic        take_vector_o,
  input wire logic [7:0]  vector_o,
  input wire logic [1:0]  active_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("upper read bits set");
  property p_take_cause; take_vector_o |-> $past(instr_done_i) && !$past(instr_is_return_from_isr_i); endproperty
  a_take_cause: assert property (p_take_cause) else $error("vector outside boundary");
  property p_preempt; take_vector_o |-> active_level_o > $past(active_level_o); endproperty
  a_preempt: assert property (p_preempt) else $error("entry without higher level");
  property p_pfail_vec; take_vector_o && active_level_o == 2'h3 |-> vector_o == PFAIL_VECTOR; endproperty
  a_pfail_vec: assert property (p_pfail_vec) else $error("power-fail vector wrong");
  property p_vec_table;
    take_vector_o && active_level_o != 2'h3 |->
      vector_o inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h63};
  endproperty
  a_vec_table: assert property (p_vec_table) else $error("vector not in table");
  property p_ret_drop;
    instr_done_i && instr_is_return_from_isr_i && active_level_o != 2'h0 |=>
      active_level_o < $past(active_level_o) && !take_vector_o;
  endproperty
  a_ret_drop: assert property (p_ret_drop) else $error("return did not drop level");
  property p_level_cause; active_level_o != $past(active_level_o) |-> take_vector_o || $past(instr_is_return_from_isr_i); endproperty
  a_level_cause: assert property (p_level_cause) else $error("level changed alone");
endmodule
bind tlp_irq_prio tlp_irq_prio_props #(.PFAIL_VECTOR(PFAIL_VECTOR)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .instr_done_i(instr_done_i), .instr_is_return_from_isr_i(instr_is_return_from_isr_i),
  .take_vector_o(take_vector_o), .vector_o(vector_o), .active_level_o(active_level_o));
`default_nettype wire

// ==== dv/tlp_core_model.sv ====
/*
  Core model: ends instructions on request and follows taken vectors.
  Assumes step is called from the bench's clocked sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module tlp_core_model (
  input  wire logic       clk_i,
  input  wire logic       take_vector_i,
  input  wire logic [7:0] vector_i,
  output logic            instr_done_o,
  output logic            instr_is_return_from_isr_o,
  output logic [7:0]      pc_vector_o
);
  initial begin
    instr_done_o = 1'b0;
    instr_is_return_from_isr_o = 1'b0;
    pc_vector_o = 8'h00;
  end
  // Whole instruction ends before any entry
  task automatic step(input logic r);
    @(posedge clk_i);
    instr_done_o <= 1'b1;
    instr_is_return_from_isr_o <= r;
    @(posedge clk_i);
    instr_done_o <= 1'b0;
    instr_is_return_from_isr_o <= 1'b0;
  endtask
  always @(posedge clk_i) if (take_vector_i) pc_vector_o <= vector_i;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
/*
  Self-checking bench: register model and arbitration model versus the block.
  Assumes the core model in tlp_core_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tlp_pkg::*;
  localparam logic [7:0] PFV = 8'h33;  // Arbitrary value
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, take, done, ret, baud;
  logic [9:0] adr = 10'h000;
  logic [31:0] dw = 32'h0, dr;
  logic [7:0] tcr = 8'h00, s0 = 8'h00, s1 = 8'h00, t2 = 8'h00, vec, pcv;
  logic adc = 1'b0, e0n = 1'b1, e2 = 1'b0, pf = 1'b0, ovr = 1'b0, txe = 1'b0, rxa = 1'b0;
  logic [1:0] act;
  logic [7:0] en_r = 8'h00, lv_r = 8'h00, een_r = 8'h00, elv_r = 8'h00, flg = 8'h00, e2c = 8'h00;
  logic [3:0] mk = 4'h0;
  logic guard = 1'b0;
  logic [7:0] vt [0:10] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h63, PFV};
  logic [7:0] ra [0:7] = '{8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE4, 8'hE8, 8'hF8, 8'h90};
  integer seed = 32'hAAAAA8BF;
  int failures = 0, checks = 0;
  always #10 clk_i = ~clk_i;
  tlp_irq_prio #(.PFAIL_VECTOR(PFV)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .timer_control_reg_i(tcr), .serial0_control_reg_i(s0), .serial1_control_reg_i(s1),
    .timer2_control_reg_i(t2), .adc_event_i(adc), .ext0_request_n_i(e0n), .ext2_request_i(e2),
    .power_fail_i(pf), .spi_rx_overrun_i(ovr), .spi_tx_empty_i(txe), .spi_rx_avail_i(rxa),
    .instr_done_i(done), .instr_is_return_from_isr_i(ret), .take_vector_o(take), .vector_o(vec),
    .active_level_o(act), .serial1_baud_double_o(baud));
  tlp_core_model core (.clk_i(clk_i), .take_vector_i(take), .vector_i(vec), .instr_done_o(done),
    .instr_is_return_from_isr_o(ret), .pc_vector_o(pcv));
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %0t register read %h, model %h", $time, g, e);
    end
  endtask
  task automatic chk_core(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %0t core side %h, model %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dw <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w && idx inside {TLP_IDX_ENABLE, TLP_IDX_LEVEL, TLP_IDX_EXT_EN, TLP_IDX_EXT_LVL}) guard = 1'b1;
  endtask
  function automatic logic [7:0] model_reg(input logic [7:0] idx);
    case (idx)
      8'h91: return flg | 8'h08;
      8'hA8: return en_r;
      8'hB8: return lv_r | 8'h80;
      8'hD8: return e2c | 8'h40;
      8'hE4: return ovr ? 8'h01 : txe ? 8'h03 : rxa ? 8'h05 : 8'h00;
      8'hE8: return een_r | 8'hE0;
      8'hF8: return elv_r;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check_regs();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      bus(ra[i], 1'b0, 8'h00, q);
      chk_reg(q, {24'h000000, model_reg(ra[i])});
    end
  endtask
  function automatic logic pick(input logic [7:0] s, input logic [7:0] e, input int i);
    return (i < 7) ? s[i] : (i == 7) ? e[0] : (i == 8) ? e[1] : e[4];
  endfunction
  task automatic step(input logic r);
    logic [9:0] rq;
    int w, wl, sl, a;
    logic t;
    // Let stimulus launched at the last edge settle before modelling
    @(posedge clk_i);
    rq = {e2c[3], flg[5], flg[4], |s1[1:0], |t2[7:6], |s0[1:0], tcr[7], tcr[3], tcr[5], tcr[1]};
    w = -1;
    wl = 0;
    for (int i = 9; i >= 0; i--) begin
      sl = 1 + int'(pick(lv_r, elv_r, i));
      if (rq[i] && en_r[7] && pick(en_r, een_r, i) && sl >= wl) begin
        w = i;
        wl = sl;
      end
    end
    if (pf) begin
      w = 10;
      wl = 3;
    end
    a = mk[3] ? 3 : mk[2] ? 2 : mk[1] ? 1 : 0;
    t = !r && !guard && w >= 0 && wl > a;
    core.step(r);
    @(posedge clk_i);
    chk_core({7'h0, take}, {7'h0, t});
    if (t) begin
      mk[wl] = 1'b1;
      chk_core(vec, vt[w]);
      // Core model latches the vector at the edge after the pulse
      @(posedge clk_i);
      chk_core(pcv, vt[w]);
    end
    if (r) mk[a] = 1'b0;
    guard = 1'b0;
    a = mk[3] ? 3 : mk[2] ? 2 : mk[1] ? 1 : 0;
    chk_core({6'h0, act}, 8'(a));
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] d;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check_regs();
    for (int k = 0; k < 40; k++) begin
      d = rnd();
      @(posedge clk_i);
      adc <= d[0];
      e0n <= ~d[1];
      e2 <= d[2];
      @(posedge clk_i);
      adc <= 1'b0;
      e0n <= 1'b1;
      e2 <= 1'b0;
      flg = flg | {2'b00, d[1], d[0], 4'h0};
      e2c[3] = e2c[3] | d[2];
      en_r = rnd();
      bus(TLP_IDX_ENABLE, 1'b1, en_r, q);
      lv_r = rnd() & 8'h7F;
      bus(TLP_IDX_LEVEL, 1'b1, lv_r, q);
      een_r = rnd() & 8'h13;
      bus(TLP_IDX_EXT_EN, 1'b1, een_r, q);
      elv_r = rnd() & 8'h13;
      bus(TLP_IDX_EXT_LVL, 1'b1, elv_r, q);
      {ovr, txe, rxa} <= d[6:4];
      check_regs();
      chk_core({7'h0, baud}, {7'h0, e2c[7]});
      repeat (4) begin
        step(1'b0);
        tcr <= rnd();
        s0 <= rnd() & 8'h83;
        s1 <= rnd() & 8'h83;
        t2 <= rnd() & 8'hC0;
      end
      flg = 8'h00;
      e2c = d & 8'h80;
      bus(TLP_IDX_EXT_FLAGS, 1'b1, 8'h00, q);
      bus(TLP_IDX_EXT2_CTL, 1'b1, e2c, q);
      {tcr, s0, s1, t2} <= 32'h0;
      repeat (3) if (mk != 4'h0) step(1'b1);
      step(1'b0);
    end
    en_r = 8'h00;
    bus(TLP_IDX_ENABLE, 1'b1, 8'h00, q);
    step(1'b0);
    pf <= 1'b1;
    step(1'b0);
    pf <= 1'b0;
    step(1'b1);
    step(1'b0);
    report_and_stop();
  end
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
